// ### logic/power_mode_cfg.svh
/*
  Constants for the power mode and clock controller: register offsets,
  field positions, reset values and timing counts.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef POWER_MODE_CFG_SVH
`define POWER_MODE_CFG_SVH

// ==========================================================
// Register byte offsets (printed indices times four)
// ==========================================================
`define IDX_SYSTEM_CLOCK_SELECT 8'h8f
`define ADDR_SYSTEM_CLOCK_SELECT 12'h023c
`define ADDR_POWER_CONTROL_REG 12'h0400
`define ADDR_WAKE_MASK 12'h0404
`define ADDR_WAKE_SOURCE_EN 12'h0408
`define ADDR_STATUS 12'h040c

// ==========================================================
// Field positions
// ==========================================================
`define POWER_CONTROL_REG_IDLE_BIT 0
`define POWER_CONTROL_REG_STOP_BIT 1
`define POWER_CONTROL_REG_SLEEP_BIT 2
`define SYSTEM_CLOCK_SELECT_SRC_LSB 0
`define SYSTEM_CLOCK_SELECT_SETTLE_LSB 2
`define SYSTEM_CLOCK_SELECT_DIV_LSB 4

// ==========================================================
// Reset values
// ==========================================================
`define SYSTEM_CLOCK_SELECT_RESET 8'h00
`define POWER_CONTROL_REG_RESET 3'h0
`define WAKE_MASK_RESET 11'h7ff
`define WAKE_EN_RESET 11'h000

// ==========================================================
// Timing: slow oscillator cycles for regulator settling, pclk cycles for oscillator restart
// ==========================================================
`define SETTLE_BASE_CYCLES 8'h10
`define OSC_START_CYCLES 4'h2

`endif

// ### logic/power_mode_pkg.sv
/*
  Types for the power mode and clock controller.
  Assumes no surroundings; used by package::name only.
*/
package power_mode_pkg;

  // Power sequencer states, one-hot
  typedef enum logic [5:0] {
    st_settle = 6'b00_0001,
    st_run = 6'b00_0010,
    st_idle = 6'b00_0100,
    st_osc_off = 6'b00_1000,
    st_stop = 6'b01_0000,
    st_osc_start = 6'b10_0000
  } power_state_t;

  // System clock sources
  typedef enum logic [1:0] {
    src_internal_osc = 2'h0,
    src_slow_osc = 2'h1,
    src_rtc = 2'h2,
    src_pll = 2'h3
  } clock_source_t;

endpackage

// ### logic/wake_detect.sv
/*
  Wake detection for stop and sleep: qualifies each wake source by
  its interrupt enable and wake mask, with pin levels active low and
  peripheral flags active high. Assumes raw inputs synchronised.
*/
`timescale 1ns/1ps
module wake_detect (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [10:0] wake_src,
  input wire logic [10:0] src_polarity_high,
  input wire logic [10:0] irq_enable,
  input wire logic [10:0] wake_mask,
  output logic wake_any
);

  logic [10:0] hit;

  // Per source qualification
  genvar i;
  generate
    for (i = 0; i < 11; i = i + 1) begin : g_src
      assign hit[i] = (src_polarity_high[i] ? wake_src[i] : ~wake_src[i])
                      & irq_enable[i] & wake_mask[i];
    end
  endgenerate

  // Registered wake request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_any <= 1'b0;
    end else begin
      wake_any <= |hit;
    end
  end

endmodule // wake_detect

// ### logic/power_mode_clock_controller.sv
/*
  Power mode and system clock controller: idle, stop and sleep
  sequencing, oscillator shutdown and restart, regulator control and
  clock source selection, with an APB register slave.
  Assumes one clock pclk, pins and peripheral flags asynchronous.
*/
// Our own choice: the APB register port.
// How it works
// - Idle bit gates CPU and core peripheral clocks; outer peripherals run.
// - Idle ends on reset pin or any enabled external interrupt.
// - Idle wake restarts CPU clock and requests vector to waking handler.
// - Hardware clears idle bit on return to normal.
// - Stop bit halts every clock except the real time clock.
// - Oscillator is shut down on its last clock edge at stop entry.
// - Only reset, lines zero to eight, comparator and RTC end stop.
// - Stop wake needs both interrupt enable and wake mask bit set.
// - Pins wake on low level, peripheral flags wake on high level.
// - Wake restarts oscillator; CPU resumes after it has run for OSC_START_CYCLES clocks.
// - After stop wake CPU runs internal oscillator and vectors at once.
// - Hardware clears stop bit during wake-up.
// - Stop plus sleep bits: as stop, main regulator and bandgap off.
// - Sleep ends like stop and turns main regulator back on.
// - Stop wake forces clock source select to internal oscillator.
// - Internal oscillator enabled in all modes except stop and sleep.
// - Internal oscillator defaults to calibrated frequency after reset.
// - No protection against selecting an unavailable clock source.
// - Two-bit source field selects clock; resets to internal oscillator.
// - Regulator settle delay of 16 to 128 slow cycles after reset or sleep.
// - Wake mask bit lets its line wake from stop, on the level.
`timescale 1ns/1ps
`include "power_mode_cfg.svh"
module power_mode_clock_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic [8:0] ext_irq_n,
  input wire logic comparator_flag,
  input wire logic rtc_flag,
  input wire logic slow_osc_tick,
  input wire logic internal_osc_running,
  output logic cpu_clock_en,
  output logic core_periph_clock_en,
  output logic periph_clock_en,
  output logic internal_osc_en,
  output logic main_regulator_en,
  output logic backup_regulator_en,
  output logic wake_vector_req,
  output logic [1:0] clock_source_field,
  output logic [3:0] osc_divider
);

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic [13:0] sync_a;
  logic [13:0] sync_b;
  logic [10:0] wake_src;
  logic [10:0] irq_seen;
  logic rst_pin_low;
  logic osc_ok;
  logic slow_tick;

  // Two flops for every asynchronous pin and flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 14'h3fff;
      sync_b <= 14'h3fff;
    end else begin
      sync_a <= {external_reset_pin_n, ext_irq_n, ~comparator_flag, ~rtc_flag,
                 ~internal_osc_running, ~slow_osc_tick};
      sync_b <= sync_a;
    end
  end

  assign rst_pin_low = ~sync_b[13];
  assign wake_src = {sync_b[12:4], ~sync_b[3], ~sync_b[2]};
  assign osc_ok = ~sync_b[1];
  assign slow_tick = ~sync_b[0];

  // Pins low, peripheral flags high
  localparam logic [10:0] POLARITY = 11'h003;

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0] system_clock_select;
  logic [2:0] power_control_reg;
  logic [10:0] wake_mask;
  logic [10:0] wake_source_en;
  power_mode_pkg::power_state_t state;
  power_mode_pkg::power_state_t next_state;
  logic wake_any;
  logic idle_wake;
  logic sleep_entered;
  logic [7:0] settle_cnt;
  logic [3:0] osc_cnt;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign addr_ok = (paddr == `ADDR_SYSTEM_CLOCK_SELECT) | (paddr == `ADDR_POWER_CONTROL_REG) |
                   (paddr == `ADDR_WAKE_MASK) | (paddr == `ADDR_WAKE_SOURCE_EN) |
                   (paddr == `ADDR_STATUS);

  // Wake detection block
  wake_detect u_wake (
    .pclk(pclk),
    .presetn(presetn),
    .wake_src(wake_src),
    .src_polarity_high(POLARITY),
    .irq_enable(wake_source_en),
    .wake_mask(wake_mask),
    .wake_any(wake_any)
  );

  // Idle wake: any enabled interrupt, mask not needed
  assign idle_wake = |(wake_source_en & (POLARITY ~^ wake_src));

  // Clock select: software writes, forced on stop wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_clock_select <= `SYSTEM_CLOCK_SELECT_RESET;
    end else if (state == power_mode_pkg::st_osc_start) begin
      system_clock_select[`SYSTEM_CLOCK_SELECT_SRC_LSB +: 2] <= power_mode_pkg::src_internal_osc;
    end else if (wr_en && paddr == `ADDR_SYSTEM_CLOCK_SELECT) begin
      system_clock_select <= pwdata[7:0];
    end
  end

  // Power control: software sets, hardware clears on wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_control_reg <= `POWER_CONTROL_REG_RESET;
    end else if (state == power_mode_pkg::st_idle && next_state == power_mode_pkg::st_run) begin
      power_control_reg[`POWER_CONTROL_REG_IDLE_BIT] <= 1'b0;
    end else if (state == power_mode_pkg::st_osc_start) begin
      power_control_reg <= `POWER_CONTROL_REG_RESET;
    end else if (wr_en && paddr == `ADDR_POWER_CONTROL_REG && state == power_mode_pkg::st_run) begin
      power_control_reg <= pwdata[2:0];
    end
  end

  // Wake mask and interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_mask <= `WAKE_MASK_RESET;
      wake_source_en <= `WAKE_EN_RESET;
    end else if (wr_en && paddr == `ADDR_WAKE_MASK) begin
      wake_mask <= pwdata[10:0];
    end else if (wr_en && paddr == `ADDR_WAKE_SOURCE_EN) begin
      wake_source_en <= pwdata[10:0];
    end
  end

  // APB answer: zero wait states, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (rd_en) begin
        case (paddr)
          `ADDR_SYSTEM_CLOCK_SELECT: prdata <= {24'h00_0000, system_clock_select};
          `ADDR_POWER_CONTROL_REG: prdata <= {29'h0000_0000, power_control_reg};
          `ADDR_WAKE_MASK: prdata <= {21'h00_0000, wake_mask};
          `ADDR_WAKE_SOURCE_EN: prdata <= {21'h00_0000, wake_source_en};
          `ADDR_STATUS: prdata <= {26'h000_0000, state};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================================
  // Power sequencer
  // ==========================================================
  always_comb begin
    next_state = state;
    case (state)
      power_mode_pkg::st_settle: begin
        if (settle_cnt == 8'h00) next_state = power_mode_pkg::st_run;
      end
      power_mode_pkg::st_run: begin
        if (power_control_reg[`POWER_CONTROL_REG_STOP_BIT]) next_state = power_mode_pkg::st_osc_off;
        else if (power_control_reg[`POWER_CONTROL_REG_IDLE_BIT]) next_state = power_mode_pkg::st_idle;
      end
      power_mode_pkg::st_idle: begin
        if (idle_wake || rst_pin_low) next_state = power_mode_pkg::st_run;
      end
      power_mode_pkg::st_osc_off: begin
        next_state = power_mode_pkg::st_stop;
      end
      power_mode_pkg::st_stop: begin
        if (wake_any || rst_pin_low) next_state = power_mode_pkg::st_osc_start;
      end
      power_mode_pkg::st_osc_start: begin
        if (osc_ok && osc_cnt == 4'h0) begin
          next_state = sleep_entered ? power_mode_pkg::st_settle : power_mode_pkg::st_run;
        end
      end
      default: next_state = power_mode_pkg::st_settle;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= power_mode_pkg::st_settle;
    end else begin
      state <= next_state;
    end
  end

  // Sleep memory for regulator control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_entered <= 1'b0;
    end else if (state == power_mode_pkg::st_run && next_state == power_mode_pkg::st_osc_off) begin
      sleep_entered <= power_control_reg[`POWER_CONTROL_REG_SLEEP_BIT];
    end else if (state == power_mode_pkg::st_settle && next_state == power_mode_pkg::st_run) begin
      sleep_entered <= 1'b0;
    end
  end

  // Settle delay counted in slow oscillator ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt <= `SETTLE_BASE_CYCLES;
    end else if (state != power_mode_pkg::st_settle) begin
      settle_cnt <= 8'(`SETTLE_BASE_CYCLES << system_clock_select[`SYSTEM_CLOCK_SELECT_SETTLE_LSB +: 2]);
    end else if (slow_tick && settle_cnt != 8'h00) begin
      settle_cnt <= settle_cnt - 8'h01;
    end
  end

  // Oscillator restart wait before opening gates
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt <= `OSC_START_CYCLES;
    end else if (state != power_mode_pkg::st_osc_start) begin
      osc_cnt <= `OSC_START_CYCLES;
    end else if (osc_ok && osc_cnt != 4'h0) begin
      osc_cnt <= osc_cnt - 4'h1;
    end
  end

  // ==========================================================
  // Clock gates, oscillator and regulators
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clock_en <= 1'b0;
      core_periph_clock_en <= 1'b0;
      periph_clock_en <= 1'b0;
      internal_osc_en <= 1'b1;
      main_regulator_en <= 1'b1;
      backup_regulator_en <= 1'b0;
      clock_source_field <= 2'h0;
      osc_divider <= 4'h0;
    end else begin
      cpu_clock_en <= (next_state == power_mode_pkg::st_run);
      core_periph_clock_en <= (next_state == power_mode_pkg::st_run);
      periph_clock_en <= (next_state == power_mode_pkg::st_run) ||
                         (next_state == power_mode_pkg::st_idle);
      internal_osc_en <= (next_state != power_mode_pkg::st_stop);
      main_regulator_en <= !((next_state == power_mode_pkg::st_stop) && sleep_entered) ||
                           (next_state != power_mode_pkg::st_stop);
      backup_regulator_en <= (next_state == power_mode_pkg::st_stop) && sleep_entered;
      clock_source_field <= system_clock_select[`SYSTEM_CLOCK_SELECT_SRC_LSB +: 2];
      osc_divider <= system_clock_select[`SYSTEM_CLOCK_SELECT_DIV_LSB +: 4];
    end
  end

  // One-cycle vector request when an interrupt wake resumes the CPU
  // Sleep wake pulses once the regulator settle delay has ended
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_vector_req <= 1'b0;
    end else begin
      wake_vector_req <= (next_state == power_mode_pkg::st_run) && !rst_pin_low &&
                         ((state == power_mode_pkg::st_idle) ||
                          (state == power_mode_pkg::st_osc_start) ||
                          (state == power_mode_pkg::st_settle && sleep_entered));
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  chk_idle_gates: assert property (@(posedge pclk) disable iff (!presetn)
    state == power_mode_pkg::st_idle |-> !cpu_clock_en && periph_clock_en)
    else $error("idle did not gate cpu clock");
  chk_idle_clear: assert property (@(posedge pclk) disable iff (!presetn)
    state == power_mode_pkg::st_idle && next_state == power_mode_pkg::st_run
    |=> !power_control_reg[`POWER_CONTROL_REG_IDLE_BIT])
    else $error("idle bit not cleared");
  chk_stop_osc: assert property (@(posedge pclk) disable iff (!presetn)
    state == power_mode_pkg::st_stop |-> !internal_osc_en && !periph_clock_en)
    else $error("clocks running in stop");
  sequence s_osc_off;
    state == power_mode_pkg::st_osc_off;
  endsequence
  chk_stop_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_osc_off |=> state == power_mode_pkg::st_stop)
    else $error("stop not reached after oscillator shutdown");
  chk_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
    state == power_mode_pkg::st_osc_start |=> power_control_reg == 3'h0)
    else $error("stop bit not cleared on wake");
  chk_src_forced: assert property (@(posedge pclk) disable iff (!presetn)
    state == power_mode_pkg::st_osc_start |=> system_clock_select[1:0] == 2'h0)
    else $error("clock source not forced on wake");
  chk_sleep_reg: assert property (@(posedge pclk) disable iff (!presetn)
    state == power_mode_pkg::st_stop && sleep_entered |-> backup_regulator_en && !main_regulator_en)
    else $error("sleep regulators wrong");
  chk_gate_hold: assert property (@(posedge pclk) disable iff (!presetn)
    state == power_mode_pkg::st_osc_start && !osc_ok |=> !cpu_clock_en)
    else $error("gate opened before oscillator restart");
  chk_vector_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    wake_vector_req |=> !wake_vector_req)
    else $error("vector request longer than one cycle");
  chk_idle_exit: assert property (@(posedge pclk) disable iff (!presetn)
    state == power_mode_pkg::st_idle && (idle_wake || rst_pin_low)
    |=> state == power_mode_pkg::st_run && cpu_clock_en)
    else $error("idle not left on wake");
  chk_osc_restart: assert property (@(posedge pclk) disable iff (!presetn)
    state == power_mode_pkg::st_osc_start |-> internal_osc_en)
    else $error("oscillator not restarted on wake");

endmodule // power_mode_clock_controller

// ### testbench/osc_partner.sv
/*
  Far-side model: internal oscillator and slow oscillator tick.
  Assumes pclk free running and the enable driven by the controller.
*/
`timescale 1ns/1ps
module osc_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic internal_osc_en,
  output logic internal_osc_running,
  output logic slow_osc_tick
);
  logic [1:0] tick_div;
  logic [1:0] start_cnt;
  // ==========================================================
  // Slow oscillator tick, one pulse every four cycles
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_div <= 2'h0;
    end else begin
      tick_div <= tick_div + 2'h1;
    end
  end
  assign slow_osc_tick = (tick_div == 2'h3);
  // ==========================================================
  // Oscillator stops at once, restarts four cycles after enable
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cnt <= 2'h0;
      internal_osc_running <= 1'b1;
    end else if (!internal_osc_en) begin
      start_cnt <= 2'h0;
      internal_osc_running <= 1'b0;
    end else if (start_cnt != 2'h3) begin
      start_cnt <= start_cnt + 2'h1;
    end else begin
      internal_osc_running <= 1'b1;
    end
  end
endmodule // osc_partner

// ### testbench/tb_top.sv
/*
  Self-checking bench for the power mode and clock controller.
  Assumes the design header on the include path and osc_partner.
*/
`timescale 1ns/1ps
`include "power_mode_cfg.svh"
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v;
  logic pready, pslverr, err, tick, osc_run, cpu_en, core_en, per_en, osc_en, main_en, bak_en, vec;
  logic rst_pin_n = 1, cmp_flag = 0, rtc_flag = 0;
  logic [8:0] irq_n = 9'h1ff;
  logic [1:0] src;
  logic [3:0] div;
  int bad_count = 0, checked = 0, vec_count = 0, line, n0;
  always #2 pclk = ~pclk;
  // Wake vector pulse counter
  always @(posedge pclk) if (vec === 1'b1) vec_count <= vec_count + 1;
  power_mode_clock_controller u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_reset_pin_n(rst_pin_n), .ext_irq_n(irq_n), .comparator_flag(cmp_flag), .rtc_flag(rtc_flag),
    .slow_osc_tick(tick), .internal_osc_running(osc_run), .cpu_clock_en(cpu_en),
    .core_periph_clock_en(core_en), .periph_clock_en(per_en), .internal_osc_en(osc_en),
    .main_regulator_en(main_en), .backup_regulator_en(bak_en), .wake_vector_req(vec),
    .clock_source_field(src), .osc_divider(div));
  osc_partner u_osc (.pclk(pclk), .presetn(presetn), .internal_osc_en(osc_en),
    .internal_osc_running(osc_run), .slow_osc_tick(tick));
  // ==========================================================
  // Compare and report
  // ==========================================================
  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // APB master and helpers
  // ==========================================================
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) chk_bit("pready", 1'b1, 1'b0);
  endtask
  task automatic wait_state(input logic [5:0] s);
    int n;
    n = 0;
    do begin
      apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
      n++;
    end while (rd[5:0] !== s && n < 400);
    chk_val("status", {26'h0, s}, rd);
  endtask
  // Wake register bit of a source: 0 pin line, 1 comparator, 2 rtc
  function automatic logic [31:0] src_bit(input int k);
    case (k)
      0: return 32'h0000_0004 << line;
      1: return 32'h0000_0002;
      default: return 32'h0000_0001;
    endcase
  endfunction
  task automatic set_src(input int k, input logic on);
    case (k)
      0: irq_n[line] <= !on;
      1: cmp_flag <= on;
      default: rtc_flag <= on;
    endcase
  endtask
  // ==========================================================
  // Watchdog
  // ==========================================================
  initial begin
    #80000;
    bad_count++;
    tally_and_finish();
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    v = $urandom(62);
    line = $urandom_range(8, 0);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wait_state(power_mode_pkg::st_run);
    chk_bit("cpu_en", 1'b1, cpu_en);
    chk_bit("osc_en", 1'b1, osc_en);
    chk_bit("bak_en", 1'b0, bak_en);
    apb(1'b0, `ADDR_SYSTEM_CLOCK_SELECT, 32'h0000_0000);
    chk_val("system_clock_select", 32'h0000_0000, rd);
    apb(1'b0, `ADDR_WAKE_MASK, 32'h0000_0000);
    chk_val("mask", 32'h0000_07ff, rd);
    apb(1'b0, 12'h0ff0, 32'h0000_0000);
    chk_bit("unmapped", 1'b1, err);
    chk_val("unmapped", 32'h0000_0000, rd);
    // Every clock source with a random divider
    for (int s = 0; s < 4; s++) begin
      v = ($urandom & 32'h0000_00f0) | s;
      apb(1'b1, `ADDR_SYSTEM_CLOCK_SELECT, v);
      apb(1'b0, `ADDR_SYSTEM_CLOCK_SELECT, 32'h0000_0000);
      chk_val("system_clock_select", v, rd);
      chk_val("src", v & 32'h0000_0003, {30'h0, src});
      chk_val("div", v[7:4], {28'h0, div});
    end
    // Idle: enabled but unmasked line still wakes
    apb(1'b1, `ADDR_WAKE_SOURCE_EN, src_bit(0));
    apb(1'b1, `ADDR_WAKE_MASK, 32'h0000_0000);
    apb(1'b1, `ADDR_POWER_CONTROL_REG, 32'h0000_0001);
    wait_state(power_mode_pkg::st_idle);
    chk_bit("cpu_en", 1'b0, cpu_en);
    chk_bit("core_en", 1'b0, core_en);
    chk_bit("per_en", 1'b1, per_en);
    chk_bit("osc_en", 1'b1, osc_en);
    n0 = vec_count;
    set_src(0, 1'b1);
    wait_state(power_mode_pkg::st_run);
    chk_val("vec", n0 + 1, vec_count);
    apb(1'b0, `ADDR_POWER_CONTROL_REG, 32'h0000_0000);
    chk_val("power_control_reg", 32'h0000_0000, rd);
    set_src(0, 1'b0);
    // Stop on pin line and rtc, sleep on comparator; neighbour enabled but unmasked
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `ADDR_WAKE_SOURCE_EN, src_bit(k) | src_bit((k + 1) % 3));
      apb(1'b1, `ADDR_WAKE_MASK, src_bit(k));
      apb(1'b1, `ADDR_POWER_CONTROL_REG, (k == 1) ? 32'h0000_0006 : 32'h0000_0002);
      wait_state(power_mode_pkg::st_stop);
      chk_bit("osc_en", 1'b0, osc_en);
      chk_bit("per_en", 1'b0, per_en);
      chk_bit("cpu_en", 1'b0, cpu_en);
      chk_bit("main_en", k != 1, main_en);
      chk_bit("bak_en", k == 1, bak_en);
      set_src((k + 1) % 3, 1'b1);
      repeat (30) @(posedge pclk);
      wait_state(power_mode_pkg::st_stop);
      n0 = vec_count;
      set_src(k, 1'b1);
      wait_state(power_mode_pkg::st_run);
      chk_bit("cpu_en", 1'b1, cpu_en);
      chk_val("vec", n0 + 1, vec_count);
      // Software rests 20 us after a sleep wake while the regulator settles
      if (k == 1) begin
        repeat (5000) @(posedge pclk);
      end
      chk_bit("main_en", 1'b1, main_en);
      chk_val("src", 32'h0000_0000, {30'h0, src});
      apb(1'b0, `ADDR_SYSTEM_CLOCK_SELECT, 32'h0000_0000);
      chk_val("system_clock_select", v & 32'h0000_00fc, rd);
      apb(1'b0, `ADDR_POWER_CONTROL_REG, 32'h0000_0000);
      chk_val("power_control_reg", 32'h0000_0000, rd);
      set_src(k, 1'b0);
      set_src((k + 1) % 3, 1'b0);
      v = ($urandom & 32'h0000_00fc) | (k + 1);
      apb(1'b1, `ADDR_SYSTEM_CLOCK_SELECT, v);
    end
    // Reset pin ends stop, internal oscillator selected beforehand
    apb(1'b1, `ADDR_SYSTEM_CLOCK_SELECT, v & 32'h0000_00fc);
    apb(1'b1, `ADDR_POWER_CONTROL_REG, 32'h0000_0002);
    wait_state(power_mode_pkg::st_stop);
    rst_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    rst_pin_n <= 1'b1;
    wait_state(power_mode_pkg::st_run);
    apb(1'b0, `ADDR_POWER_CONTROL_REG, 32'h0000_0000);
    chk_val("power_control_reg", 32'h0000_0000, rd);
    tally_and_finish();
  end
endmodule // tb_top
